// ### src/fpasn_adder.sv
// True addition of two in-range or zero extended operands, one cycle latency.
// Assumes operands arrive already in normalized or denormalized form.
`timescale 1ns/1ps
module fpasn_adder (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Operands and rounding mode
  input wire fpasn_pkg::fpasn_ext_type op_a,
  input wire fpasn_pkg::fpasn_ext_type op_b,
  input wire logic [1:0] rmode,
  // Registered sum
  output fpasn_pkg::fpasn_ext_type sum
);
  import fpasn_pkg::*;

  fpasn_add_state_type st_ff;
  fpasn_add_state_type nxt_st;
  logic [15:0] ea;
  logic [15:0] eb;
  logic a_big;
  logic [15:0] big_e;
  logic [15:0] diff;
  logic [66:0] big_x;
  logic [66:0] sml_x;
  logic [67:0] raw;
  fpasn_norm_type n;

  ////////////////////////////////////////////////////////////////////////////////
  // Align, add or subtract, renormalize
  // Guard bits are truncated; no stage rounds the sum, rmode only picks the sign of an exact zero
  always_comb begin
    nxt_st = st_ff;
    ea = fpasn_eff_exp(op_a.exp);
    eb = fpasn_eff_exp(op_b.exp);
    a_big = {ea, op_a.mant} >= {eb, op_b.mant};
    big_e = a_big ? ea : eb;
    diff = a_big ? (ea - eb) : (eb - ea);
    big_x = a_big ? {op_a.mant, 3'h0} : {op_b.mant, 3'h0};
    sml_x = a_big ? {op_b.mant, 3'h0} : {op_a.mant, 3'h0};
    sml_x = (diff >= fpasn_shift_cap) ? 67'h0 : (sml_x >> diff);
    if (op_a.sign == op_b.sign) begin
      raw = {1'h0, big_x} + {1'h0, sml_x};
    end else begin
      raw = {1'h0, big_x} - {1'h0, sml_x};
    end
    if (raw[67]) begin
      n.exp = big_e + 16'h0001;
      n.mant = raw[67:1];
    end else begin
      n = fpasn_normalize(big_e, raw[66:0]);
    end
    nxt_st.sum.sign = a_big ? op_a.sign : op_b.sign;
    nxt_st.sum.exp = n.exp[14:0];
    nxt_st.sum.mant = n.mant[66:3];
    if (raw == 68'h0) begin
      // Exact cancellation: sign of zero follows the rounding mode
      nxt_st.sum.sign = (rmode == fpasn_rm_down);
      nxt_st.sum.exp = 15'h0000;
      nxt_st.sum.mant = 64'h0;
    end else if (n.exp >= {1'h0, fpasn_exp_max}) begin
      nxt_st.sum.exp = fpasn_exp_max;
      nxt_st.sum.mant = 64'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sum = st_ff.sum;

endmodule

// ### src/fpasn_pkg.sv
// Shared constants, types and helpers for the floating-point add result block.
// Assumes a single clock domain and a plain 32-bit register port.
package fpasn_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port carrier and map
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wr_data;
    logic wr_en;
    logic rd_en;
  } fpasn_bus_req_type;

  localparam logic [7:0] fpasn_ctrl_off = 8'h00;
  localparam logic [7:0] fpasn_stat_off = 8'h04;
  localparam logic [7:0] fpasn_cmd_off = 8'h08;
  localparam logic [7:0] fpasn_int_stat_off = 8'h0c;
  localparam logic [7:0] fpasn_int_mask_off = 8'h10;
  localparam logic [7:0] fpasn_src_lo_off = 8'h14;
  localparam logic [7:0] fpasn_src_mid_off = 8'h18;
  localparam logic [7:0] fpasn_src_hi_off = 8'h1c;
  localparam logic [7:0] fpasn_dst_lo_off = 8'h20;
  localparam logic [7:0] fpasn_dst_mid_off = 8'h24;
  localparam logic [7:0] fpasn_dst_hi_off = 8'h28;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int fpasn_ctrl_signaling_nan_flag_en_bit = 8;
  localparam int fpasn_ctrl_rmode_lo = 0;
  localparam int fpasn_cmd_start_bit = 0;
  localparam int fpasn_stat_cc_lo = 24;
  localparam int fpasn_stat_signaling_nan_flag_bit = 8;
  localparam int fpasn_stat_operand_error_flag_bit = 9;
  localparam int fpasn_stat_busy_bit = 0;
  localparam int fpasn_hi_sign_bit = 15;
  localparam int fpasn_int_done_bit = 0;
  localparam int fpasn_int_operand_error_flag_bit = 1;
  localparam int fpasn_int_signaling_nan_flag_bit = 2;
  localparam int fpasn_int_trap_bit = 3;
  localparam int fpasn_quiet_bit = 62;
  localparam logic [31:0] fpasn_rd_zero = 32'h0000_0000;
  localparam logic [3:0] fpasn_int_reset = 4'h0;
  localparam logic [1:0] fpasn_rmode_reset = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Rounding mode codes
  localparam logic [1:0] fpasn_rm_nearest = 2'h0;
  localparam logic [1:0] fpasn_rm_zero = 2'h1;
  localparam logic [1:0] fpasn_rm_down = 2'h2;
  localparam logic [1:0] fpasn_rm_up = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Number format
  localparam logic [14:0] fpasn_exp_max = 15'h7fff;
  localparam logic [15:0] fpasn_shift_cap = 16'h0043;
  localparam logic [79:0] fpasn_default_nan = 80'h7fff_ffff_ffff_ffff_ffff;

  typedef struct packed {
    logic sign;
    logic [14:0] exp;
    logic [63:0] mant;
  } fpasn_ext_type;

  // Mantissa widened by three guard bits below the explicit integer bit
  typedef struct packed {
    logic [15:0] exp;
    logic [66:0] mant;
  } fpasn_norm_type;

  typedef enum logic [2:0] {
    fpasn_cls_zero,
    fpasn_cls_range,
    fpasn_cls_inf,
    fpasn_cls_qnan,
    fpasn_cls_signaling_nan_flag
  } fpasn_class_type;

  typedef enum logic [1:0] {
    fpasn_st_idle,
    fpasn_st_add,
    fpasn_st_wb
  } fpasn_state_type;

  typedef struct packed {
    fpasn_ext_type sum;
  } fpasn_add_state_type;

  typedef struct packed {
    fpasn_state_type state;
    logic ctrl_signaling_nan_flag_en;
    logic [1:0] rmode;
    fpasn_ext_type src;
    fpasn_ext_type dst;
    logic [3:0] cc;
    logic exc_operand_error_flag;
    logic exc_signaling_nan_flag;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic [31:0] rd_data;
    logic irq;
  } fpasn_top_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Denormals share the smallest normal exponent
  function automatic logic [15:0] fpasn_eff_exp(input logic [14:0] e);
    return (e == 15'h0000) ? 16'h0001 : {1'h0, e};
  endfunction

  // Shift left until the integer bit is set or the exponent floor is hit;
  // what stays unnormalized at the floor is stored as a denormal.
  function automatic fpasn_norm_type fpasn_normalize(input logic [15:0] e,
                                                     input logic [66:0] m);
    fpasn_norm_type r;
    r.exp = e;
    r.mant = m;
    for (int i = 0; i < 67; i++) begin
      if (!r.mant[66] && (r.exp > 16'h0001)) begin
        r.mant = r.mant << 1;
        r.exp = r.exp - 16'h0001;
      end
    end
    if (!r.mant[66]) begin
      r.exp = 16'h0000;
    end
    return r;
  endfunction

  function automatic fpasn_class_type fpasn_classify(input fpasn_ext_type v);
    if (v.exp == fpasn_exp_max) begin
      if (v.mant[fpasn_quiet_bit:0] == 63'h0) begin
        return fpasn_cls_inf;
      end
      if (v.mant[fpasn_quiet_bit]) begin
        return fpasn_cls_qnan;
      end
      return fpasn_cls_signaling_nan_flag;
    end
    if (v.mant == 64'h0) begin
      return fpasn_cls_zero;
    end
    return fpasn_cls_range;
  endfunction

endpackage

// ### src/fpasn_top.sv
// Result selection for the floating-point add: special operands, NaNs, flags.
// Assumes software loads operands and starts an add over the register port.
`timescale 1ns/1ps
module fpasn_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire fpasn_pkg::fpasn_bus_req_type bus_req,
  output logic [31:0] rd_data,
  // Interrupt
  output logic irq
);
  import fpasn_pkg::*;

  fpasn_top_state_type st_ff;
  fpasn_top_state_type nxt_st;
  fpasn_ext_type add_a;
  fpasn_ext_type add_b;
  fpasn_ext_type add_sum;
  fpasn_ext_type qs;
  fpasn_ext_type qd;
  fpasn_ext_type res;
  fpasn_class_type src_c;
  fpasn_class_type dst_c;
  logic s_nan;
  logic d_nan;
  logic s_inf;
  logic d_inf;
  logic signaling_nan_flag_seen;
  logic nan_any;
  logic both_zero;
  logic take_trap;
  logic operand_error_flag;
  logic [3:0] ev;
  logic wb;
  logic idle;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic fpasn_ext_type fpasn_to_internal(input fpasn_ext_type v);
    fpasn_norm_type n;
    fpasn_ext_type r;
    n = fpasn_normalize(fpasn_eff_exp(v.exp), {v.mant, 3'h0});
    r.sign = v.sign;
    r.exp = n.exp[14:0];
    r.mant = n.mant[66:3];
    return r;
  endfunction

  function automatic logic [3:0] fpasn_cc(input fpasn_ext_type v);
    fpasn_class_type c;
    c = fpasn_classify(v);
    return {v.sign, c == fpasn_cls_zero, c == fpasn_cls_inf,
            (c == fpasn_cls_qnan) || (c == fpasn_cls_signaling_nan_flag)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Adder; operands are converted on entry so unnormals never reach it
  assign add_a = fpasn_to_internal(st_ff.dst);
  assign add_b = fpasn_to_internal(st_ff.src);

  fpasn_adder u_adder (
    .sys_clk(sys_clk),
    .reset(reset),
    .op_a(add_a),
    .op_b(add_b),
    .rmode(st_ff.rmode),
    .sum(add_sum)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Operand classes; NaN handling ignores the rest of the class table
  always_comb begin
    src_c = fpasn_classify(st_ff.src);
    dst_c = fpasn_classify(st_ff.dst);
    s_nan = (src_c == fpasn_cls_qnan) || (src_c == fpasn_cls_signaling_nan_flag);
    d_nan = (dst_c == fpasn_cls_qnan) || (dst_c == fpasn_cls_signaling_nan_flag);
    s_inf = (src_c == fpasn_cls_inf);
    d_inf = (dst_c == fpasn_cls_inf);
    nan_any = s_nan || d_nan;
    signaling_nan_flag_seen = (src_c == fpasn_cls_signaling_nan_flag) || (dst_c == fpasn_cls_signaling_nan_flag);
    both_zero = (src_c == fpasn_cls_zero) && (dst_c == fpasn_cls_zero);
    qs = st_ff.src;
    qd = st_ff.dst;
    qs.mant[fpasn_quiet_bit] = st_ff.src.mant[fpasn_quiet_bit] | s_nan;
    qd.mant[fpasn_quiet_bit] = st_ff.dst.mant[fpasn_quiet_bit] | d_nan;
    wb = (st_ff.state == fpasn_st_wb);
    idle = (st_ff.state == fpasn_st_idle);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result selection
  always_comb begin
    res = add_sum;
    take_trap = 1'h0;
    operand_error_flag = 1'h0;
    if (signaling_nan_flag_seen && st_ff.ctrl_signaling_nan_flag_en) begin
      take_trap = 1'h1;
      res = st_ff.dst;
    end else if (d_nan) begin
      res = qd;
    end else if (s_nan) begin
      res = qs;
    end else if (s_inf && d_inf && (st_ff.src.sign != st_ff.dst.sign)) begin
      res = fpasn_default_nan;
      operand_error_flag = 1'h1;
    end else if (s_inf || d_inf) begin
      res = '0;
      res.sign = d_inf ? st_ff.dst.sign : st_ff.src.sign;
      res.exp = fpasn_exp_max;
    end else if (both_zero) begin
      res = '0;
      if (st_ff.src.sign == st_ff.dst.sign) begin
        res.sign = st_ff.dst.sign;
      end else begin
        res.sign = (st_ff.rmode == fpasn_rm_down);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port, sequencer and interrupt
  // Operand writes and starts are ignored while busy so the add sees stable inputs
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_data = fpasn_rd_zero;
    ev = 4'h0;
    if (bus_req.wr_en) begin
      case (bus_req.addr)
        fpasn_ctrl_off: begin
          nxt_st.ctrl_signaling_nan_flag_en = bus_req.wr_data[fpasn_ctrl_signaling_nan_flag_en_bit];
          nxt_st.rmode = bus_req.wr_data[fpasn_ctrl_rmode_lo +: 2];
        end
        fpasn_cmd_off: begin
          if (idle && bus_req.wr_data[fpasn_cmd_start_bit]) begin
            nxt_st.state = fpasn_st_add;
            nxt_st.exc_operand_error_flag = 1'h0;
            nxt_st.exc_signaling_nan_flag = 1'h0;
          end
        end
        fpasn_int_stat_off: begin
          nxt_st.int_status = st_ff.int_status & ~bus_req.wr_data[3:0];
        end
        fpasn_int_mask_off: begin
          nxt_st.int_mask = bus_req.wr_data[3:0];
        end
        fpasn_src_lo_off: begin
          if (idle) begin
            nxt_st.src.mant[31:0] = bus_req.wr_data;
          end
        end
        fpasn_src_mid_off: begin
          if (idle) begin
            nxt_st.src.mant[63:32] = bus_req.wr_data;
          end
        end
        fpasn_src_hi_off: begin
          if (idle) begin
            nxt_st.src.sign = bus_req.wr_data[fpasn_hi_sign_bit];
            nxt_st.src.exp = bus_req.wr_data[14:0];
          end
        end
        fpasn_dst_lo_off: begin
          if (idle) begin
            nxt_st.dst.mant[31:0] = bus_req.wr_data;
          end
        end
        fpasn_dst_mid_off: begin
          if (idle) begin
            nxt_st.dst.mant[63:32] = bus_req.wr_data;
          end
        end
        fpasn_dst_hi_off: begin
          if (idle) begin
            nxt_st.dst.sign = bus_req.wr_data[fpasn_hi_sign_bit];
            nxt_st.dst.exp = bus_req.wr_data[14:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (bus_req.rd_en) begin
      case (bus_req.addr)
        fpasn_ctrl_off: begin
          nxt_st.rd_data[fpasn_ctrl_signaling_nan_flag_en_bit] = st_ff.ctrl_signaling_nan_flag_en;
          nxt_st.rd_data[fpasn_ctrl_rmode_lo +: 2] = st_ff.rmode;
        end
        fpasn_stat_off: begin
          nxt_st.rd_data[fpasn_stat_cc_lo +: 4] = st_ff.cc;
          nxt_st.rd_data[fpasn_stat_operand_error_flag_bit] = st_ff.exc_operand_error_flag;
          nxt_st.rd_data[fpasn_stat_signaling_nan_flag_bit] = st_ff.exc_signaling_nan_flag;
          nxt_st.rd_data[fpasn_stat_busy_bit] = !idle;
        end
        fpasn_int_stat_off: nxt_st.rd_data[3:0] = st_ff.int_status;
        fpasn_int_mask_off: nxt_st.rd_data[3:0] = st_ff.int_mask;
        fpasn_src_lo_off: nxt_st.rd_data = st_ff.src.mant[31:0];
        fpasn_src_mid_off: nxt_st.rd_data = st_ff.src.mant[63:32];
        fpasn_src_hi_off: nxt_st.rd_data[15:0] = {st_ff.src.sign, st_ff.src.exp};
        fpasn_dst_lo_off: nxt_st.rd_data = st_ff.dst.mant[31:0];
        fpasn_dst_mid_off: nxt_st.rd_data = st_ff.dst.mant[63:32];
        fpasn_dst_hi_off: nxt_st.rd_data[15:0] = {st_ff.dst.sign, st_ff.dst.exp};
        default: nxt_st.rd_data = fpasn_rd_zero;
      endcase
    end
    case (st_ff.state)
      fpasn_st_idle: begin
      end
      fpasn_st_add: begin
        nxt_st.state = fpasn_st_wb;
      end
      fpasn_st_wb: begin
        nxt_st.state = fpasn_st_idle;
        nxt_st.exc_signaling_nan_flag = st_ff.exc_signaling_nan_flag | signaling_nan_flag_seen;
        nxt_st.exc_operand_error_flag = st_ff.exc_operand_error_flag | operand_error_flag;
        if (!take_trap) begin
          nxt_st.dst = res;
          nxt_st.cc = fpasn_cc(res);
        end
        ev[fpasn_int_done_bit] = 1'h1;
        ev[fpasn_int_operand_error_flag_bit] = operand_error_flag;
        ev[fpasn_int_signaling_nan_flag_bit] = signaling_nan_flag_seen;
        ev[fpasn_int_trap_bit] = take_trap;
      end
      default: begin
        nxt_st.state = fpasn_st_idle;
      end
    endcase
    // An event in the same cycle as its clear stays set
    nxt_st.int_status = nxt_st.int_status | ev;
    nxt_st.irq = |(nxt_st.int_status & nxt_st.int_mask);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.state <= fpasn_st_idle;
      st_ff.rmode <= fpasn_rmode_reset;
      st_ff.int_status <= fpasn_int_reset;
      st_ff.int_mask <= fpasn_int_reset;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd_data;
  assign irq = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence seq_start;
    idle && bus_req.wr_en && (bus_req.addr == fpasn_cmd_off) &&
      bus_req.wr_data[fpasn_cmd_start_bit];
  endsequence

  sequence seq_run;
    (st_ff.state == fpasn_st_add) ##1 (st_ff.state == fpasn_st_wb) ##1 idle;
  endsequence

  chk_op_sequence: assert property (seq_start |=> seq_run)
    else $error("add did not run add then writeback then idle");

  chk_true_sum_path: assert property (
    (wb && !nan_any && !s_inf && !d_inf && !both_zero) |=> (st_ff.dst == $past(add_sum)))
    else $error("in-range add did not return the adder sum");

  chk_zero_sign_mode: assert property (
    (wb && both_zero && (st_ff.src.sign != st_ff.dst.sign)) |=>
      (st_ff.dst.exp == 15'h0000) && (st_ff.dst.mant == 64'h0) &&
      (st_ff.dst.sign == ($past(st_ff.rmode) == fpasn_rm_down)))
    else $error("opposite zero sum has wrong sign");

  chk_single_inf: assert property (
    (wb && !nan_any && (s_inf != d_inf)) |=>
      (st_ff.dst.exp == fpasn_exp_max) && !st_ff.exc_operand_error_flag &&
      (st_ff.dst.sign == $past(d_inf ? st_ff.dst.sign : st_ff.src.sign)))
    else $error("single infinity not returned with its sign");

  chk_opposite_inf: assert property (
    (wb && !nan_any && s_inf && d_inf && (st_ff.src.sign != st_ff.dst.sign)) |=>
      st_ff.exc_operand_error_flag && st_ff.int_status[fpasn_int_operand_error_flag_bit] && st_ff.cc[0])
    else $error("opposite infinities did not give NaN and operand error");

  chk_entry_normal: assert property (
    (st_ff.state == fpasn_st_add) |->
      (add_a.mant[63] || (add_a.exp == 15'h0000)) &&
      (add_b.mant[63] || (add_b.exp == 15'h0000)))
    else $error("adder operand not normalized on entry");

  chk_qnan_single: assert property (
    (wb && (src_c == fpasn_cls_qnan) && !d_nan) |=> (st_ff.dst == $past(st_ff.src)))
    else $error("single quiet NaN not returned unchanged");

  chk_both_nan_dst: assert property (
    (wb && (src_c == fpasn_cls_qnan) && (dst_c == fpasn_cls_qnan)) |=> $stable(st_ff.dst))
    else $error("two quiet NaNs did not keep the destination NaN");

  chk_signaling_nan_flag_flag: assert property (
    (wb && signaling_nan_flag_seen) |=> st_ff.exc_signaling_nan_flag && st_ff.int_status[fpasn_int_signaling_nan_flag_bit])
    else $error("signaling NaN flag not set");

  chk_trap_keeps_dst: assert property (
    (wb && signaling_nan_flag_seen && st_ff.ctrl_signaling_nan_flag_en) |=>
      $stable(st_ff.dst) && $stable(st_ff.cc) && st_ff.int_status[fpasn_int_trap_bit])
    else $error("trap taken but destination changed");

  chk_signaling_nan_flag_quieted: assert property (
    (wb && (src_c == fpasn_cls_signaling_nan_flag) && !d_nan && !st_ff.ctrl_signaling_nan_flag_en) |=>
      st_ff.dst.mant[fpasn_quiet_bit] && (st_ff.dst.exp == fpasn_exp_max) &&
      (st_ff.dst.mant[61:0] == $past(st_ff.src.mant[61:0])))
    else $error("signaling NaN not quieted into the result");

  chk_cc_follow: assert property (
    (wb && !take_trap) |=> (st_ff.cc == fpasn_cc(st_ff.dst)))
    else $error("condition bits do not match the result");

  chk_read_window: assert property (
    !bus_req.rd_en |=> (rd_data == fpasn_rd_zero))
    else $error("read data outside its one-cycle window");

endmodule

// ### tb/fpasn_host.sv
// Host model: issues register writes and reads on the plain register port.
// Assumes rd_data is valid only in the cycle after the read strobe.
`timescale 1ns/1ps
module fpasn_host (
  // Clock
  input wire logic sys_clk,
  // Register port
  output fpasn_pkg::fpasn_bus_req_type bus_req,
  input wire logic [31:0] rd_data
);
  import fpasn_pkg::*;
  initial bus_req = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // A gap cycle after each strobe keeps one assignment per signal per step
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wr_data: d, wr_en: 1'b1, rd_en: 1'b0};
    @(posedge sys_clk);
    bus_req <= '{addr: ~a, wr_data: ~d, wr_en: 1'b0, rd_en: 1'b0};
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wr_data: 32'h0000_0000, wr_en: 1'b0, rd_en: 1'b1};
    @(posedge sys_clk);
    bus_req <= '{addr: ~a, wr_data: 32'hffff_ffff, wr_en: 1'b0, rd_en: 1'b0};
    #1 d = rd_data;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the floating-point add result block.
// Assumes the host model and the design package; expectations are reckoned here.
`timescale 1ns/1ps
module tb;
  import fpasn_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  fpasn_bus_req_type bus_req;
  logic [31:0] rd_data;
  logic irq;
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'hf9cdc441;
  logic [3:0] prev_cc = 4'h0;
  fpasn_ext_type e_res;
  logic [3:0] e_cc;
  logic e_operand_error_flag, e_signaling_nan_flag, e_trap;
  always #50 sys_clk = ~sys_clk;
  fpasn_top DUT (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
    .irq(irq));
  fpasn_host host (.sys_clk(sys_clk), .bus_req(bus_req), .rd_data(rd_data));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [79:0] e, input logic [79:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic int cls(input fpasn_ext_type v);
    if (v.exp == 15'h7fff) return (v.mant[62:0] == 63'h0) ? 2 : (v.mant[62] ? 3 : 4);
    return (v.mant == 64'h0) ? 0 : 1;
  endfunction
  function automatic fpasn_ext_type rnd_val(input int c);
    fpasn_ext_type v;
    logic [31:0] r0, r1, r2;
    r0 = $random(seed);
    r1 = $random(seed);
    r2 = $random(seed);
    v = {r2[15:0], r1, r0};
    case (c)
      0: v = {v.sign, 79'h0};
      1: begin
        v.exp = (v.exp % 15'h7ffd) + 15'h0001;
        v.mant[63] = 1'b1;
      end
      2: v = {v.sign, 15'h7fff, 64'h0};
      3: {v.exp, v.mant[62]} = {15'h7fff, 1'b1};
      default: {v.exp, v.mant[62], v.mant[0]} = {15'h7fff, 2'b01};
    endcase
    return v;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic predict(input fpasn_ext_type s, d, input logic [1:0] rm, input logic trap);
    int cs, cd;
    fpasn_ext_type qs, qd;
    logic [64:0] sm;
    cs = cls(s);
    cd = cls(d);
    qs = s;
    qd = d;
    qs.mant[62] = 1'b1;
    qd.mant[62] = 1'b1;
    e_signaling_nan_flag = (cs == 4) || (cd == 4);
    e_trap = e_signaling_nan_flag && trap;
    e_operand_error_flag = 1'b0;
    if (cd >= 3) e_res = qd;
    else if (cs >= 3) e_res = qs;
    else if (cs == 2 && cd == 2 && s.sign != d.sign) begin
      e_res = fpasn_default_nan;
      e_operand_error_flag = 1'b1;
    end else if (cd == 2) e_res = d;
    else if (cs == 2) e_res = s;
    else if (cs == 0 && cd == 0) begin
      e_res = {(s.sign == d.sign) ? s.sign : (rm == fpasn_rm_down), 79'h0};
    end else if (cs == 1 && cd == 1 && s.sign != d.sign) begin
      e_res = {rm == fpasn_rm_down, 79'h0};
    end else if (cs == 1 && cd == 1) begin
      sm = {1'b0, s.mant} + {1'b0, d.mant};
      e_res = {s.sign, s.exp + 15'h0001, sm[64:1]};
    end else begin
      e_res = (cs == 0) ? d : s;
      while (!e_res.mant[63] && e_res.exp > 15'h0001) begin
        e_res.mant = e_res.mant << 1;
        e_res.exp = e_res.exp - 15'h0001;
      end
    end
    e_cc = {e_res.sign, e_res.exp != 15'h7fff && e_res.mant == 64'h0,
      e_res.exp == 15'h7fff && e_res.mant[62:0] == 63'h0,
      e_res.exp == 15'h7fff && e_res.mant[62:0] != 63'h0};
    if (e_trap) begin
      e_res = d;
      e_cc = prev_cc;
    end
    prev_cc = e_cc;
  endtask
  task automatic run_op(input fpasn_ext_type s, d, input logic [1:0] rm, input logic trap);
    logic [31:0] w0, w1, w2, st;
    int n;
    predict(s, d, rm, trap);
    host.bus_wr(fpasn_ctrl_off, {23'h0, trap, 6'h0, rm});
    host.bus_wr(fpasn_src_lo_off, s.mant[31:0]);
    host.bus_wr(fpasn_src_mid_off, s.mant[63:32]);
    host.bus_wr(fpasn_src_hi_off, {16'h0, s.sign, s.exp});
    host.bus_wr(fpasn_dst_lo_off, d.mant[31:0]);
    host.bus_wr(fpasn_dst_mid_off, d.mant[63:32]);
    host.bus_wr(fpasn_dst_hi_off, {16'h0, d.sign, d.exp});
    host.bus_wr(fpasn_int_stat_off, 32'h0000_000f);
    host.bus_wr(fpasn_cmd_off, 32'h0000_0001);
    st = 32'h0000_0001;
    for (n = 0; n < 20 && st[0] !== 1'b0; n++) host.bus_rd(fpasn_stat_off, st);
    host.bus_rd(fpasn_dst_lo_off, w0);
    host.bus_rd(fpasn_dst_mid_off, w1);
    host.bus_rd(fpasn_dst_hi_off, w2);
    check("result", e_res, {w2[15:0], w1, w0});
    check("cc", 80'(e_cc), 80'(st[27:24]));
    check("flags", 80'({e_operand_error_flag, e_signaling_nan_flag}), 80'(st[9:8]));
    host.bus_rd(fpasn_int_stat_off, w0);
    check("int status", 80'({e_trap, e_signaling_nan_flag, e_operand_error_flag}), 80'(w0[3:1]));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    fpasn_ext_type a, b;
    logic [31:0] w;
    int ca, cb;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    for (int m = 0; m < 4; m++) run_op({1'b1, 79'h0}, {1'b0, 79'h0}, 2'(m), 1'b0);
    run_op({1'b0, 15'h3fff, 64'h4000_0000_0000_0000}, 80'h0, fpasn_rm_nearest, 1'b0);
    run_op({1'b0, 15'h4000, 64'h8000_0000_0000_0001}, {1'b1, 15'h4000, 64'h8000_0000_0000_0001},
      fpasn_rm_down, 1'b0);
    host.bus_wr(fpasn_int_mask_off, 32'h0000_0002);
    run_op({1'b0, 79'h0}, {1'b0, 79'h0}, fpasn_rm_zero, 1'b0);
    #1 check("irq masked", 80'h0, 80'(irq));
    run_op({1'b0, 15'h7fff, 64'h0}, {1'b1, 15'h7fff, 64'h0}, fpasn_rm_up, 1'b0);
    #1 check("irq set", 80'h1, 80'(irq));
    host.bus_wr(fpasn_int_stat_off, 32'h0000_0002);
    #1 check("irq cleared", 80'h0, 80'(irq));
    host.bus_rd(8'h40, w);
    check("unmapped", 80'h0, 80'(w));
    host.bus_rd(fpasn_cmd_off, w);
    check("cmd read", 80'h0, 80'(w));
    for (int i = 0; i < 60; i++) begin
      ca = $unsigned($random(seed)) % 5;
      cb = $unsigned($random(seed)) % 5;
      a = rnd_val(ca);
      b = rnd_val(cb);
      if (ca == 1 && cb == 1) {b.sign, b.exp} = {a.sign, a.exp};
      run_op(a, b, 2'($random(seed)), 1'($random(seed)));
    end
    tally_and_finish();
  end
endmodule
